// file: acp_defines.svh
// Register map, field positions, reset values and timing constants of the parameter unit.
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACP_A_PEAK   8'h00
`define ACP_A_MIN    8'h04
`define ACP_A_INIT   8'h08
`define ACP_A_TBE    8'h0c
`define ACP_A_FIXED_ROUND_TRIP_TIME   8'h10
`define ACP_A_FACT   8'h14
`define ACP_A_ALLOWED_RATE_DECAY_TIME   8'h18
`define ACP_A_QOS    8'h1c
`define ACP_A_CTRL   8'h20
`define ACP_A_STAT   8'h24
`define ACP_A_MRL    8'h28
`define ACP_A_ICR    8'h2c
`define ACP_A_TCR    8'h30
`define ACP_A_MRM    8'h34
`define ACP_A_ALLOW  8'h38
`define ACP_A_AFLT   8'h3c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACP_F_RIF    3:0
`define ACP_F_RDF    7:4
`define ACP_F_NRM    11:8
`define ACP_F_TRM    14:12
`define ACP_F_CDF    18:16
`define ACP_F_SEL    15:8
`define ACP_F_ALLOWED_RATE_DECAY_TIME   9:0
`define ACP_F_QOS    7:0
`define ACP_C_COMMIT 0
`define ACP_C_RESET  1
// ----------------------------------------
// Reset values, limits and constants
// ----------------------------------------
`define ACP_DEF_TBE  24'hff_ffff
`define ACP_DEF_FAC  4'h4
`define ACP_DEF_NRM  4'h5
`define ACP_DEF_TRM  3'h0
`define ACP_DEF_CDF  3'h4
`define ACP_DEF_ALLOWED_RATE_DECAY_TIME 10'h032
`define ACP_DEF_QOS  8'h00
`define ACP_MIN_NRM  4'h1
`define ACP_MAX_NRM  4'h8
`define ACP_CDF_ZERO 3'h7
`define ACP_TCR      24'h00_000a
`define ACP_MRM      24'h00_0002
`define ACP_US_PER_S 44'h000_000f_4240
`define ACP_ALLOWED_RATE_DECAY_TIME_MS  10
`define ACP_CLK_MHZ  100
`define ACP_TICK_CYC (`ACP_ALLOWED_RATE_DECAY_TIME_MS * `ACP_CLK_MHZ * 1000)
`endif

// file: acp_pkg.sv
// Types shared by the parameter unit modules.
`default_nettype none
`include "acp_defines.svh"
package acp_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_DIV} acp_phase_t;
  typedef struct packed {
    logic [23:0] peak;
    logic [23:0] minr;
    logic [23:0] init;
    logic        init_given;
    logic [23:0] transient_buffer_exposure;
    logic [23:0] fixed_round_trip_time;
    logic [3:0]  rate_increase_factor;
    logic [3:0]  rate_decrease_factor;
    logic [3:0]  nrm;
    logic [2:0]  trm;
    logic [2:0]  cdf;
    logic [9:0]  allowed_rate_decay_time;
    logic [7:0]  qos;
    logic [7:0]  sel;
    logic [7:0]  conn;
    acp_phase_t  ph;
    logic        start;
    logic        valid;
    logic [23:0] allowed;
    logic [23:0] mrl;
    logic [15:0] afloat;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } acp_state_t;
endpackage : acp_pkg
`default_nettype wire

// file: acp_div_if.sv
// Request and answer signals between the unit and its serial divider.
`timescale 1ns/1ps
`default_nettype none
interface acp_div_if #(parameter int NW = 44, parameter int DW = 24) ();
  logic          start;
  logic [NW-1:0] num;
  logic [DW-1:0] den;
  logic          busy;
  logic          done;
  logic [NW-1:0] quot;
  modport req (output start, output num, output den, input busy, input done, input quot);
  modport srv (input start, input num, input den, output busy, output done, output quot);
endinterface : acp_div_if
`default_nettype wire

// file: acp_divider.sv
// Serial restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module acp_divider #(
  parameter int NW = 44,
  parameter int DW = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  acp_div_if.srv   dif
);
  if (NW < 2 || NW > 255 || DW < 1 || DW > NW) begin : g_chk
    $error("acp_divider: unsupported widths");
  end
  typedef struct packed {
    logic [DW:0]   rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] den;
    logic [7:0]    cnt;
    logic          busy;
    logic          done;
  } acp_div_state_t;
  acp_div_state_t s_reg, s_next;
  logic [DW:0] rsh;
  // Division by zero yields all ones, which the caller treats as no limit.
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    rsh = {s_reg.rem[DW-1:0], s_reg.quo[NW-1]};
    if (dif.start && !s_reg.busy) begin
      s_next.rem = '0;
      s_next.quo = dif.num;
      s_next.den = dif.den;
      s_next.cnt = 8'(NW);
      s_next.busy = 1'b1;
    end else if (s_reg.busy) begin
      if (rsh >= {1'b0, s_reg.den}) begin
        s_next.rem = rsh - {1'b0, s_reg.den};
        s_next.quo = {s_reg.quo[NW-2:0], 1'b1};
      end else begin
        s_next.rem = rsh;
        s_next.quo = {s_reg.quo[NW-2:0], 1'b0};
      end
      s_next.cnt = s_reg.cnt - 8'h01;
      if (s_reg.cnt == 8'h01) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign dif.busy = s_reg.busy;
  assign dif.done = s_reg.done;
  assign dif.quot = s_reg.quo;
endmodule : acp_divider
`default_nettype wire

// file: acp_decay_timer.sv
// Counts 10 ms ticks since the last RM cell and flags when the decay time runs out.
`timescale 1ns/1ps
`default_nettype none
`include "acp_defines.svh"
module acp_decay_timer #(
  parameter int TICK_CYC = `ACP_TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       rm_sent,
  input  wire logic [9:0] limit,
  output logic            expired
);
  if (TICK_CYC < 1 || TICK_CYC > 1048576) begin : g_chk
    $error("acp_decay_timer: tick count out of range");
  end
  typedef struct packed {
    logic [19:0] pre;
    logic [9:0]  ticks;
    logic        exp;
  } acp_tmr_state_t;
  acp_tmr_state_t t_reg, t_next;
  always_comb begin
    t_next = t_reg;
    t_next.exp = 1'b0;
    if (!run || rm_sent) begin
      t_next.pre = '0;
      t_next.ticks = '0;
    end else if (t_reg.pre == 20'(TICK_CYC - 1)) begin
      t_next.pre = '0;
      if (t_reg.ticks + 10'h001 >= limit) begin
        t_next.ticks = '0;
        t_next.exp = 1'b1;
      end else begin
        t_next.ticks = t_reg.ticks + 10'h001;
      end
    end else begin
      t_next.pre = t_reg.pre + 20'h0_0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end
  assign expired = t_reg.exp;
endmodule : acp_decay_timer
`default_nettype wire

// file: acp_param_unit.sv
// Per-connection rate-adaptive service parameter store and setup calculator.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "acp_defines.svh"
// Function
// - Signaled rates are unsigned 24-bit cells per second.
// - Allowed rate never exceeds the peak rate.
// - Allowed rate never falls below the minimum rate, except when the minimum is set above the peak, where the peak wins.
// - Increase factor is a power of two, 1/32768 to 1.
// - Cells per forward RM cell is a power of two, 2 to 256.
// - Decrease factor is a power of two, 1/32768 to 1.
// - Decay time kept in 10 ms steps, 0.01 to 10.23 s.
// - No RM cell for the decay time drops allowed rate to initial.
// - RM interval bound is 100 ms times two to exponent -7..0.
// - Round-trip time held in microseconds up to 16.7 s.
// - Buffer exposure is a cell count up to 16,777,215.
// - Cutoff factor is zero or a power of two, 1/64 to 1.
// - Out-of-rate RM cell rate fixed at 10 cells per second.
// - Rates in RM cells use a 16-bit floating point form.
// - Absent optional parameters take defaults; cutoff up, decay time down.
// - Missing RM limit is ceiling of exposure over cells per RM.
// - Initial rate becomes min of itself and exposure over round trip.
// - Unsignaled service class defaults to zero.
module acp_param_unit #(
  parameter int NCONN    = 4,
  parameter int TICK_CYC = `ACP_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [23:0] rate_req,
  input  wire logic        rate_load,
  input  wire logic        rm_sent,
  output logic             params_valid,
  output logic [23:0]      allowed_rate,
  output logic [15:0]      allowed_rate_float,
  output logic [23:0]      initial_rate,
  output logic [23:0]      missing_rm_limit,
  output logic [3:0]       rate_increase_exp,
  output logic [3:0]       rate_decrease_exp,
  output logic [3:0]       rm_count_exp,
  output logic [2:0]       rm_interval_exp,
  output logic [2:0]       cutoff_code,
  output logic [9:0]       decay_time
);
  if (NCONN < 2 || NCONN > 256) begin : g_chk
    $error("acp_param_unit: NCONN must be 2 to 256");
  end
  localparam int IW = $clog2(NCONN);

  acp_pkg::acp_state_t st_reg, st_next;
  logic [23:0] mrl_mem [NCONN];
  logic [23:0] icr_mem [NCONN];
  logic        decay_exp;
  logic        setup;
  logic        acc;
  logic        err;
  logic        sel_ok;
  logic [31:0] rd;
  logic [23:0] qsat;
  logic [23:0] eff;
  logic [24:0] csum;
  logic [24:0] cmask;

  acp_div_if #(.NW(44), .DW(24)) dif ();

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [23:0] f_clamp(input logic [23:0] r, input logic [23:0] lo,
                                          input logic [23:0] hi);
    logic [23:0] v;
    v = (r < lo) ? lo : r;
    f_clamp = (v > hi) ? hi : v;
  endfunction : f_clamp

  // Exponent is the msb position, mantissa the nine bits below it, truncated.
  function automatic logic [15:0] f_float(input logic [23:0] v);
    logic [4:0]  e;
    logic [23:0] sh;
    e = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (v[i]) begin
        e = 5'(i);
      end
    end
    sh = v << (5'd23 - e);
    f_float = (v == 24'h00_0000) ? 16'h0000 : {1'b0, 1'b1, e, sh[22:14]};
  endfunction : f_float

  // A larger cutoff factor has a smaller exponent; the zero code is the smallest.
  function automatic logic f_cdf_up(input logic [2:0] nw, input logic [2:0] cur);
    f_cdf_up = (cur == `ACP_CDF_ZERO) || (nw != `ACP_CDF_ZERO && nw <= cur);
  endfunction : f_cdf_up

  function automatic acp_pkg::acp_state_t f_defaults(input acp_pkg::acp_state_t s);
    acp_pkg::acp_state_t d;
    d = s;
    d.minr = 24'h00_0000;
    d.init_given = 1'b0;
    d.transient_buffer_exposure = `ACP_DEF_TBE;
    d.rate_increase_factor = `ACP_DEF_FAC;
    d.rate_decrease_factor = `ACP_DEF_FAC;
    d.nrm = `ACP_DEF_NRM;
    d.trm = `ACP_DEF_TRM;
    d.cdf = `ACP_DEF_CDF;
    d.allowed_rate_decay_time = `ACP_DEF_ALLOWED_RATE_DECAY_TIME;
    d.qos = `ACP_DEF_QOS;
    d.valid = 1'b0;
    f_defaults = d;
  endfunction : f_defaults

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  acp_divider #(.NW(44), .DW(24)) u_div (
    .clk   (pclk),
    .rst_n (presetn),
    .dif   (dif.srv)
  );

  acp_decay_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
    .clk     (pclk),
    .rst_n   (presetn),
    .run     (st_reg.valid),
    .rm_sent (rm_sent),
    .limit   (st_reg.allowed_rate_decay_time),
    .expired (decay_exp)
  );

  // Rates are in cells per second and the round trip in microseconds.
  assign dif.start = st_reg.start;
  assign dif.num   = 44'({20'h0_0000, st_reg.transient_buffer_exposure} * `ACP_US_PER_S);
  assign dif.den   = st_reg.fixed_round_trip_time;

  // ----------------------------------------
  // Read decode and write checks
  // ----------------------------------------
  assign setup  = psel && !penable;
  assign acc    = psel && penable && st_reg.pready;
  assign sel_ok = st_reg.sel < 8'(NCONN);

  always_comb begin
    rd = 32'h0000_0000;
    err = 1'b0;
    case (paddr)
      `ACP_A_PEAK: begin
        rd = {8'h00, st_reg.peak};
        err = pwrite && (|pwdata[31:24]);
      end
      `ACP_A_MIN: begin
        rd = {8'h00, st_reg.minr};
        err = pwrite && (|pwdata[31:24]);
      end
      `ACP_A_INIT: begin
        rd = {8'h00, st_reg.init};
        err = pwrite && (|pwdata[31:24]);
      end
      `ACP_A_TBE: begin
        rd = {8'h00, st_reg.transient_buffer_exposure};
        err = pwrite && (|pwdata[31:24]);
      end
      `ACP_A_FIXED_ROUND_TRIP_TIME: begin
        rd = {8'h00, st_reg.fixed_round_trip_time};
        err = pwrite && (|pwdata[31:24]);
      end
      `ACP_A_FACT: begin
        rd = {13'h0000, st_reg.cdf, 1'b0, st_reg.trm, st_reg.nrm, st_reg.rate_decrease_factor, st_reg.rate_increase_factor};
        err = pwrite && (pwdata[`ACP_F_NRM] < `ACP_MIN_NRM || pwdata[`ACP_F_NRM] > `ACP_MAX_NRM
              || !f_cdf_up(pwdata[`ACP_F_CDF], st_reg.cdf));
      end
      `ACP_A_ALLOWED_RATE_DECAY_TIME: begin
        rd = {22'h00_0000, st_reg.allowed_rate_decay_time};
        err = pwrite && (pwdata[`ACP_F_ALLOWED_RATE_DECAY_TIME] == 10'h000 || (|pwdata[31:10])
              || pwdata[`ACP_F_ALLOWED_RATE_DECAY_TIME] > st_reg.allowed_rate_decay_time);
      end
      `ACP_A_QOS: begin
        rd = {24'h00_0000, st_reg.qos};
      end
      `ACP_A_CTRL: begin
        rd = {16'h0000, st_reg.sel, 8'h00};
        err = pwrite && (pwdata[`ACP_C_COMMIT] || pwdata[`ACP_C_RESET])
              && (st_reg.ph != acp_pkg::PH_IDLE || pwdata[`ACP_F_SEL] >= 8'(NCONN));
      end
      `ACP_A_STAT: begin
        rd = {30'h0000_0000, st_reg.valid, st_reg.ph == acp_pkg::PH_DIV};
        err = pwrite;
      end
      `ACP_A_MRL: begin
        rd = sel_ok ? {8'h00, mrl_mem[st_reg.sel[IW-1:0]]} : 32'h0000_0000;
        err = pwrite;
      end
      `ACP_A_ICR: begin
        rd = sel_ok ? {8'h00, icr_mem[st_reg.sel[IW-1:0]]} : 32'h0000_0000;
        err = pwrite;
      end
      `ACP_A_TCR: begin
        rd = {8'h00, `ACP_TCR};
        err = pwrite;
      end
      `ACP_A_MRM: begin
        rd = {8'h00, `ACP_MRM};
        err = pwrite;
      end
      `ACP_A_ALLOW: begin
        rd = {8'h00, st_reg.allowed};
        err = pwrite;
      end
      `ACP_A_AFLT: begin
        rd = {16'h0000, st_reg.afloat};
        err = pwrite;
      end
      default: begin
        err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Setup results
  // ----------------------------------------
  always_comb begin
    qsat = (|dif.quot[43:24]) ? 24'hff_ffff : dif.quot[23:0];
    eff = (qsat < st_reg.init) ? qsat : st_reg.init;
    cmask = (25'h000_0001 << st_reg.nrm) - 25'h000_0001;
    csum = {1'b0, st_reg.transient_buffer_exposure} + cmask;
    csum = csum >> st_reg.nrm;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.pready = setup;
    st_next.pslverr = setup && err;
    if (setup) begin
      st_next.prdata = rd;
    end
    if (acc && pwrite && !st_reg.pslverr) begin
      case (paddr)
        `ACP_A_PEAK: st_next.peak = pwdata[23:0];
        `ACP_A_MIN:  st_next.minr = pwdata[23:0];
        `ACP_A_INIT: begin
          st_next.init = pwdata[23:0];
          st_next.init_given = 1'b1;
        end
        `ACP_A_TBE:  st_next.transient_buffer_exposure = pwdata[23:0];
        `ACP_A_FIXED_ROUND_TRIP_TIME: st_next.fixed_round_trip_time = pwdata[23:0];
        `ACP_A_FACT: begin
          st_next.rate_increase_factor = pwdata[`ACP_F_RIF];
          st_next.rate_decrease_factor = pwdata[`ACP_F_RDF];
          st_next.nrm = pwdata[`ACP_F_NRM];
          st_next.trm = pwdata[`ACP_F_TRM];
          st_next.cdf = pwdata[`ACP_F_CDF];
        end
        `ACP_A_ALLOWED_RATE_DECAY_TIME: st_next.allowed_rate_decay_time = pwdata[`ACP_F_ALLOWED_RATE_DECAY_TIME];
        `ACP_A_QOS:  st_next.qos = pwdata[`ACP_F_QOS];
        `ACP_A_CTRL: begin
          st_next.sel = pwdata[`ACP_F_SEL];
          if (pwdata[`ACP_C_RESET]) begin
            st_next = f_defaults(st_next);
          end else if (pwdata[`ACP_C_COMMIT]) begin
            st_next.conn = pwdata[`ACP_F_SEL];
            if (!st_reg.init_given) begin
              st_next.init = st_reg.peak;
            end
            st_next.valid = 1'b0;
            st_next.start = 1'b1;
            st_next.ph = acp_pkg::PH_DIV;
          end
        end
        default: st_next.sel = st_reg.sel;
      endcase
    end
    case (st_reg.ph)
      acp_pkg::PH_DIV: begin
        if (dif.done) begin
          st_next.init = eff;
          st_next.mrl = csum[23:0];
          st_next.allowed = f_clamp(eff, st_reg.minr, st_reg.peak);
          st_next.valid = 1'b1;
          st_next.ph = acp_pkg::PH_IDLE;
        end
      end
      acp_pkg::PH_IDLE: begin
        if (st_reg.valid && decay_exp) begin
          st_next.allowed = f_clamp(st_reg.init, st_reg.minr, st_reg.peak);
        end else if (st_reg.valid && rate_load) begin
          st_next.allowed = f_clamp(rate_req, st_reg.minr, st_reg.peak);
        end
      end
      default: st_next.ph = acp_pkg::PH_IDLE;
    endcase
    st_next.afloat = f_float(st_next.allowed);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= f_defaults('0);
    end else begin
      st_reg <= st_next;
    end
  end

  // Results live per connection so that later setups do not disturb earlier ones.
  always_ff @(posedge pclk) begin
    if (st_reg.ph == acp_pkg::PH_DIV && dif.done) begin
      mrl_mem[st_reg.conn[IW-1:0]] <= csum[23:0];
      icr_mem[st_reg.conn[IW-1:0]] <= eff;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata             = st_reg.prdata;
  assign pready             = st_reg.pready;
  assign pslverr            = st_reg.pslverr;
  assign params_valid       = st_reg.valid;
  assign allowed_rate       = st_reg.allowed;
  assign allowed_rate_float = st_reg.afloat;
  assign initial_rate       = st_reg.init;
  assign missing_rm_limit   = st_reg.mrl;
  assign rate_increase_exp  = st_reg.rate_increase_factor;
  assign rate_decrease_exp  = st_reg.rate_decrease_factor;
  assign rm_count_exp       = st_reg.nrm;
  assign rm_interval_exp    = st_reg.trm;
  assign cutoff_code        = st_reg.cdf;
  assign decay_time         = st_reg.allowed_rate_decay_time;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  rate_ceiling_a: assert property (st_reg.valid && rate_load && !decay_exp && st_reg.ph == acp_pkg::PH_IDLE
    |=> allowed_rate <= $past(st_reg.peak))
    else $error("allowed rate above peak rate");

  rate_floor_a: assert property (st_reg.valid && rate_load && !decay_exp && st_reg.minr <= st_reg.peak
    && st_reg.ph == acp_pkg::PH_IDLE |=> allowed_rate >= $past(st_reg.minr))
    else $error("allowed rate below minimum rate");

  rm_count_range_a: assert property (rm_count_exp >= `ACP_MIN_NRM && rm_count_exp <= `ACP_MAX_NRM)
    else $error("cells per RM exponent out of range");

  decay_range_a: assert property (decay_time != 10'h000)
    else $error("decay time is zero");

  decay_fallback_a: assert property (st_reg.valid && decay_exp && st_reg.ph == acp_pkg::PH_IDLE
    |=> allowed_rate == f_clamp($past(st_reg.init), $past(st_reg.minr), $past(st_reg.peak)))
    else $error("rate did not fall back after decay time");

  tagged_rate_a: assert property (acc && !pwrite && paddr == `ACP_A_TCR |-> prdata == {8'h00, `ACP_TCR})
    else $error("tagged rate constant wrong");

  alloc_const_a: assert property (acc && !pwrite && paddr == `ACP_A_MRM |-> prdata == {8'h00, `ACP_MRM})
    else $error("allocation constant wrong");

  missing_rm_calc_a: assert property ($rose(params_valid) |->
    (32'(missing_rm_limit) << rm_count_exp) >= 32'(st_reg.transient_buffer_exposure)
    && (32'(missing_rm_limit) << rm_count_exp) - 32'(st_reg.transient_buffer_exposure) < (32'h0000_0001 << rm_count_exp))
    else $error("missing RM limit is not the ceiling");

  initial_update_a: assert property ($rose(params_valid) |->
    64'(initial_rate) * 64'(st_reg.fixed_round_trip_time) <= 64'(st_reg.transient_buffer_exposure) * 64'(`ACP_US_PER_S))
    else $error("initial rate exceeds exposure over round trip");

  setup_latch_a: assert property (st_reg.start |-> !params_valid ##1 dif.busy [*8])
    else $error("setup computation not started");

  class_default_a: assert property (acc && pwrite && paddr == `ACP_A_CTRL && !pslverr
    && pwdata[`ACP_C_RESET] |=> st_reg.qos == `ACP_DEF_QOS && !params_valid)
    else $error("service class default not applied");

  float_form_a: assert property (allowed_rate_float[15] == 1'b0 && allowed_rate_float[13:9] <= 5'd23
    && allowed_rate_float[14] == (allowed_rate != 24'h00_0000))
    else $error("rate float encoding malformed");

  setup_done_c: cover property (st_reg.ph == acp_pkg::PH_DIV ##1 $rose(params_valid));
  decay_hit_c: cover property (params_valid && decay_exp);
  peak_clamp_c: cover property (params_valid && rate_load && rate_req > st_reg.peak);
  bus_error_c: cover property (acc && pslverr);
endmodule : acp_param_unit
`default_nettype wire

// file: acp_source_model.sv
// Model of the source rate logic that drives load and RM pulses on command.
`timescale 1ns/1ps
`default_nettype none
module acp_source_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ld_cmd,
  input  wire logic        rm_cmd,
  input  wire logic [23:0] rate_cmd,
  output logic [23:0]      rate_req,
  output logic             rate_load,
  output logic             rm_sent
);
  // Outside a load the requested rate keeps toggling, so a stale value is never mistaken for a request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_req  <= 24'h00_0000;
      rate_load <= 1'b0;
      rm_sent   <= 1'b0;
    end else begin
      rate_req  <= ld_cmd ? rate_cmd : ~rate_req;
      rate_load <= ld_cmd;
      rm_sent   <= rm_cmd;
    end
  end
endmodule : acp_source_model
`default_nettype wire

// file: acp_param_unit_tb_top.sv
// Self-checking testbench of the parameter unit.
`timescale 1ns/1ps
`default_nettype none
`include "acp_defines.svh"
module acp_param_unit_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pv;
  logic        ld_cmd, rm_cmd, rate_load, rm_sent;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] rate_cmd, rate_req, ar, ir, mrl;
  logic [15:0] fl;
  logic [3:0]  rif_e, rdf_e, nrm_e;
  logic [2:0]  trm_e, cdf_e;
  logic [9:0]  dec_t;
  int          mismatches, compares;

  acp_param_unit #(.NCONN(4), .TICK_CYC(10)) u_acp_param_unit (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rate_req(rate_req), .rate_load(rate_load), .rm_sent(rm_sent),
    .params_valid(pv), .allowed_rate(ar), .allowed_rate_float(fl), .initial_rate(ir),
    .missing_rm_limit(mrl), .rate_increase_exp(rif_e), .rate_decrease_exp(rdf_e), .rm_count_exp(nrm_e),
    .rm_interval_exp(trm_e), .cutoff_code(cdf_e), .decay_time(dec_t));
  acp_source_model u_acp_source_model (.pclk(pclk), .presetn(presetn), .ld_cmd(ld_cmd), .rm_cmd(rm_cmd),
    .rate_cmd(rate_cmd), .rate_req(rate_req), .rate_load(rate_load), .rm_sent(rm_sent));

  always #5 pclk = ~pclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Pready is looked at mid-cycle so the value the master samples at the next edge is settled.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    chk("pslverr", pslverr, ee);
    if (!w) chk("prdata", prdata, d);
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the write settle in the design before any caller looks at its outputs.
    @(negedge pclk);
  endtask : acc

  task automatic fire(input logic l, input logic [23:0] r);
    @(posedge pclk);
    rm_cmd   <= 1'b1;
    ld_cmd   <= l;
    rate_cmd <= r;
    @(posedge pclk);
    rm_cmd <= 1'b0;
    ld_cmd <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : fire

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset();
    chk("valid", pv, 0);
    chk("decay", dec_t, 32'h0000_0032);
    acc(0, `ACP_A_FACT, 32'h0004_0544, 0);
    acc(0, `ACP_A_TBE, 32'h00ff_ffff, 0);
    acc(0, `ACP_A_ALLOWED_RATE_DECAY_TIME, 32'h0000_0032, 0);
    acc(0, `ACP_A_QOS, 32'h0000_0000, 0);
    acc(0, `ACP_A_TCR, 32'h0000_000a, 0);
    acc(0, `ACP_A_MRM, 32'h0000_0002, 0);
  endtask : s_reset

  task automatic s_refuse();
    acc(1, `ACP_A_PEAK, 32'h0100_0000, 1);
    acc(1, `ACP_A_FACT, 32'h0004_0044, 1);
    acc(1, `ACP_A_FACT, 32'h0004_0944, 1);
    acc(1, `ACP_A_FACT, 32'h0005_0544, 1);
    acc(1, `ACP_A_ALLOWED_RATE_DECAY_TIME, 32'h0000_0000, 1);
    acc(1, `ACP_A_ALLOWED_RATE_DECAY_TIME, 32'h0000_0033, 1);
    acc(1, `ACP_A_TCR, 32'h0000_0005, 1);
    acc(0, 8'h40, 32'h0000_0000, 1);
  endtask : s_refuse

  task automatic s_setup();
    int n;
    acc(1, `ACP_A_PEAK, 32'h0000_03e8, 0);
    acc(1, `ACP_A_MIN, 32'h0000_0064, 0);
    acc(1, `ACP_A_TBE, 32'h0000_01f4, 0);
    acc(1, `ACP_A_FIXED_ROUND_TRIP_TIME, 32'h000f_4240, 0);
    acc(1, `ACP_A_FACT, 32'h0004_7344, 0);
    chk("nrm", nrm_e, 3);
    chk("trm", trm_e, 7);
    chk("rif", rif_e, 4);
    chk("rdf", rdf_e, 4);
    chk("cdf", cdf_e, 4);
    acc(1, `ACP_A_ALLOWED_RATE_DECAY_TIME, 32'h0000_0002, 0);
    chk("decay", dec_t, 2);
    acc(1, `ACP_A_CTRL, 32'h0000_0001, 0);
    acc(1, `ACP_A_CTRL, 32'h0000_0001, 1);
    n = 0;
    while (pv !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk("valid", pv, 1);
    if (pv !== 1'b1) begin
      tally_and_finish();
    end
    chk("icr", ir, 32'h0000_01f4);
    chk("crm", mrl, 32'h0000_003f);
    acc(0, `ACP_A_MRL, 32'h0000_003f, 0);
  endtask : s_setup

  task automatic s_rate();
    fire(1, 24'h00_07d0);
    chk("acr", ar, 32'h0000_03e8);
    chk("float", fl, 32'h0000_53e8);
    fire(1, 24'h00_000a);
    chk("acr", ar, 32'h0000_0064);
  endtask : s_rate

  task automatic s_decay();
    fire(1, 24'h00_03e8);
    repeat (5) fire(0, 24'h00_0000);
    chk("acr", ar, 32'h0000_03e8);
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    chk("acr", ar, 32'h0000_01f4);
  endtask : s_decay

  task automatic s_defaults();
    acc(1, `ACP_A_QOS, 32'h0000_0003, 0);
    acc(0, `ACP_A_QOS, 32'h0000_0003, 0);
    acc(1, `ACP_A_CTRL, 32'h0000_0002, 0);
    chk("valid", pv, 0);
    chk("decay", dec_t, 32'h0000_0032);
    chk("nrm", nrm_e, 5);
    acc(0, `ACP_A_QOS, 32'h0000_0000, 0);
  endtask : s_defaults

  initial begin
    pclk     = 1'b0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    ld_cmd   = 1'b0;
    rm_cmd   = 1'b0;
    rate_cmd = 24'h00_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    s_reset();
    s_refuse();
    s_setup();
    s_rate();
    s_decay();
    s_defaults();
    tally_and_finish();
  end
endmodule : acp_param_unit_tb_top
`default_nettype wire
